// ===== rcic_top.sv
// relay, contact input, analog reverse, mode lockout and clock edit control
`timescale 1ns/10ps
module rcic_top #(
  parameter int DEB_CYC = rcic_pkg::DEBOUNCE_CYC,
  parameter int AN_W    = 10,
  parameter int FREQ_W  = 16
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   irq,
  input  wire logic              contact_input_1,
  input  wire logic              contact_input_2,
  input  wire logic              contact_input_3,
  input  wire logic              contact_input_4,
  input  wire logic              system_fault,
  input  wire logic              pump_fault,
  input  wire logic [FREQ_W-1:0] motor_freq,
  input  wire logic [2:0]        leadlag_relay,
  input  wire logic              config_run,
  input  wire logic              key_enter,
  input  wire logic              key_up,
  input  wire logic              key_down,
  input  wire logic              rtc_edit,
  input  wire logic [1:0]        mode_req,
  input  wire logic              mode_req_valid,
  input  wire logic [AN_W-1:0]   analog_v_in,
  input  wire logic [AN_W-1:0]   analog_i_in,
  output logic      [AN_W-1:0]   analog_v_out,
  output logic      [AN_W-1:0]   analog_i_out,
  output logic                   relay2_make_contact,
  output logic                   relay2_break_contact,
  output logic                   relay3_make_contact,
  output logic                   relay4_make_contact,
  output logic                   motor_run,
  output logic                   motor_reverse,
  output logic                   fault_display,
  output logic      [1:0]        op_mode
);
  localparam int S = rcic_pkg::FLD_STRIDE;

  logic                rst_s1_r;
  logic                rst_n;
  logic                ack_r;
  logic                wr_en;
  logic [31:0]         rdata_r;
  logic [2:0]          rsel_r [3];
  logic [2:0]          fn_r [4];
  logic                arev_r;
  logic                mdis_r;
  logic                lead_r;
  logic [2:0]          cfg_r;
  logic [FREQ_W-1:0]   minf_r;
  logic [2:0]          ist_r;
  logic [2:0]          imask_r;
  logic [3:0]          rtc_idx_r;
  logic [3:0]          rtc_dat;
  logic [3:0]          rtc_cur;
  logic [3:0]          in_raw;
  logic [3:0]          in_db;
  logic [3:0]          latch_r;
  logic [3:0]          latch_nxt;
  logic [3:0]          permit;
  logic [2:0]          relay_r;
  logic [2:0]          relay_nxt;
  logic                run_nxt;
  logic                rev_nxt;
  logic                clr_fault;
  logic [2:0]          ev;
  rcic_pkg::rcic_mode_t mode_r;
  rcic_pkg::rcic_mode_t mode_nxt;

  // reset released through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // slave answers on the second cycle of every request
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_en           = avs_write && ack_r;
  assign avs_readdata    = rdata_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  // out of range select keeps old value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) rsel_r[i] <= rcic_pkg::SEL_SYS_FAULT;
    end else if (wr_en && avs_address == rcic_pkg::OFS_RELAY_CFG) begin
      for (int i = 0; i < 3; i++) begin
        if (avs_writedata[i*S +: 3] <= rcic_pkg::SEL_MAX) begin
          rsel_r[i] <= avs_writedata[i*S +: 3];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fn_r[0] <= rcic_pkg::FN_RST_LOW;
      fn_r[1] <= rcic_pkg::FN_RST_LOW;
      fn_r[2] <= rcic_pkg::FN_RST_HIGH;
      fn_r[3] <= rcic_pkg::FN_RST_HIGH;
    end else if (wr_en && avs_address == rcic_pkg::OFS_INPUT_CFG) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_writedata[i*S +: 3] <= ((i < 2) ? rcic_pkg::FN_MAX_LOW
                                                : rcic_pkg::FN_MAX_HIGH)) begin
          fn_r[i] <= avs_writedata[i*S +: 3];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arev_r <= 1'b0;
      mdis_r <= 1'b0;
      lead_r <= 1'b0;
      cfg_r  <= rcic_pkg::CFG_DEFAULT;
    end else if (wr_en && avs_address == rcic_pkg::OFS_MISC_CFG) begin
      arev_r <= avs_writedata[rcic_pkg::MISC_AREV];
      mdis_r <= avs_writedata[rcic_pkg::MISC_MDIS];
      lead_r <= avs_writedata[rcic_pkg::MISC_LEAD];
      cfg_r  <= avs_writedata[rcic_pkg::MISC_CFG_LSB +: 3];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      minf_r    <= '0;
      rtc_idx_r <= 4'h0;
      imask_r   <= 3'h0;
    end else if (wr_en) begin
      if (avs_address == rcic_pkg::OFS_MIN_FREQ) begin
        minf_r <= avs_writedata[FREQ_W-1:0];
      end else if (avs_address == rcic_pkg::OFS_RTC) begin
        rtc_idx_r <= avs_writedata[3:0];
      end else if (avs_address == rcic_pkg::OFS_IRQ_MASK) begin
        imask_r <= avs_writedata[2:0];
      end
    end
  end

  // read data latched on the edge that raises ack
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else if (avs_read && !ack_r) begin
      rdata_r <= 32'h0;
      if (avs_address == rcic_pkg::OFS_RELAY_CFG) begin
        for (int i = 0; i < 3; i++) rdata_r[i*S +: 3] <= rsel_r[i];
      end else if (avs_address == rcic_pkg::OFS_INPUT_CFG) begin
        for (int i = 0; i < 4; i++) rdata_r[i*S +: 3] <= fn_r[i];
      end else if (avs_address == rcic_pkg::OFS_MISC_CFG) begin
        rdata_r[rcic_pkg::MISC_AREV]        <= arev_r;
        rdata_r[rcic_pkg::MISC_MDIS]        <= mdis_r;
        rdata_r[rcic_pkg::MISC_LEAD]        <= lead_r;
        rdata_r[rcic_pkg::MISC_CFG_LSB +: 3] <= cfg_r;
      end else if (avs_address == rcic_pkg::OFS_MIN_FREQ) begin
        rdata_r[FREQ_W-1:0] <= minf_r;
      end else if (avs_address == rcic_pkg::OFS_STATUS) begin
        rdata_r[3:0]                         <= in_db;
        rdata_r[7:4]                         <= latch_r;
        rdata_r[rcic_pkg::ST_RUN]            <= motor_run;
        rdata_r[rcic_pkg::ST_REV]            <= motor_reverse;
        rdata_r[rcic_pkg::ST_RELAY_LSB +: 3] <= relay_r;
        rdata_r[rcic_pkg::ST_MODE_LSB +: 2]  <= mode_r;
      end else if (avs_address == rcic_pkg::OFS_IRQ_STAT) begin
        rdata_r[2:0] <= ist_r;
      end else if (avs_address == rcic_pkg::OFS_IRQ_MASK) begin
        rdata_r[2:0] <= imask_r;
      end else if (avs_address == rcic_pkg::OFS_RTC) begin
        rdata_r[3:0]                        <= rtc_dat;
        rdata_r[rcic_pkg::RTC_CUR_LSB +: 4] <= rtc_cur;
      end
    end
  end

  assign in_raw = {contact_input_4, contact_input_3, contact_input_2, contact_input_1};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_in
      rcic_debounce #(
        .DEB_CYC (DEB_CYC)
      ) u_deb (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      (in_raw[g]),
        .dout     (in_db[g])
      );
    end
  endgenerate

  // enter clears latched faults only outside clock editing
  assign clr_fault = key_enter && !rtc_edit;

  always_comb begin
    latch_nxt = latch_r;
    for (int i = 0; i < 4; i++) begin
      if (clr_fault) latch_nxt[i] = 1'b0;
      if (fn_r[i] == rcic_pkg::FN_LATCH_OPEN && !in_db[i]) latch_nxt[i] = 1'b1;
      if (i >= 2 && fn_r[i] == rcic_pkg::FN_LATCH_CLS && in_db[i]) latch_nxt[i] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= 4'h0;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  always_comb begin
    rev_nxt = 1'b0;
    for (int i = 0; i < 4; i++) begin
      permit[i] = 1'b1;
      case (fn_r[i])
        rcic_pkg::FN_RUN_STOP:   permit[i] = in_db[i];
        rcic_pkg::FN_ALWAYS:     permit[i] = 1'b1;
        rcic_pkg::FN_LATCH_OPEN: permit[i] = !latch_r[i];
        rcic_pkg::FN_LATCH_CLS:  permit[i] = !latch_r[i];
        default:                 permit[i] = 1'b1;
      endcase
      if (i >= 2 && fn_r[i] == rcic_pkg::FN_REVERSE && in_db[i]) rev_nxt = 1'b1;
    end
  end

  // other configurations supply their own run request
  always_comb begin
    run_nxt = 1'b0;
    if (mode_r == rcic_pkg::RCIC_AUTO) begin
      run_nxt = (cfg_r == rcic_pkg::CFG_DEFAULT) ? &permit : config_run;
    end else if (mode_r == rcic_pkg::RCIC_MANUAL) begin
      run_nxt = !(|latch_r);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_run     <= 1'b0;
      motor_reverse <= 1'b0;
    end else begin
      motor_run     <= run_nxt;
      motor_reverse <= rev_nxt && (cfg_r == rcic_pkg::CFG_DEFAULT);
    end
  end

  assign fault_display = |latch_r;

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      rcic_pkg::RCIC_MANUAL: if (mdis_r) mode_nxt = rcic_pkg::RCIC_OFF;
      default:               mode_nxt = mode_r;
    endcase
    if (mode_req_valid) begin
      if (mode_req == rcic_pkg::REQ_OFF) mode_nxt = rcic_pkg::RCIC_OFF;
      else if (mode_req == rcic_pkg::REQ_AUTO) mode_nxt = rcic_pkg::RCIC_AUTO;
      else if (mode_req == rcic_pkg::REQ_MANUAL && !mdis_r) mode_nxt = rcic_pkg::RCIC_MANUAL;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= rcic_pkg::RCIC_OFF;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign op_mode = mode_r;

  // reserved codes leave the relay open
  generate
    for (g = 0; g < 3; g++) begin : g_rly
      always_comb begin
        case (rsel_r[g])
          rcic_pkg::SEL_SYS_FAULT: relay_nxt[g] = !system_fault;
          rcic_pkg::SEL_PUMP:      relay_nxt[g] = !pump_fault;
          rcic_pkg::SEL_MIN_FREQ:  relay_nxt[g] = motor_freq > minf_r;
          default:                 relay_nxt[g] = 1'b0;
        endcase
        if (lead_r) relay_nxt[g] = leadlag_relay[g];
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_r <= 3'h0;
    end else begin
      relay_r <= relay_nxt;
    end
  end

  assign relay2_make_contact  = relay_r[0];
  assign relay2_break_contact = !relay_r[0];
  assign relay3_make_contact  = relay_r[1];
  assign relay4_make_contact  = relay_r[2];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_v_out <= '0;
      analog_i_out <= '0;
    end else begin
      analog_v_out <= arev_r ? ~analog_v_in : analog_v_in;
      analog_i_out <= arev_r ? ~analog_i_in : analog_i_in;
    end
  end

  // a new event wins over a same-cycle clear
  assign ev[rcic_pkg::IRQ_LATCH] = |(latch_nxt & ~latch_r);
  assign ev[rcic_pkg::IRQ_RUN]   = run_nxt != motor_run;
  assign ev[rcic_pkg::IRQ_RELAY] = relay_nxt != relay_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ist_r <= 3'h0;
    end else if (wr_en && avs_address == rcic_pkg::OFS_IRQ_STAT) begin
      ist_r <= (ist_r & ~avs_writedata[2:0]) | ev;
    end else begin
      ist_r <= ist_r | ev;
    end
  end

  assign irq = |(ist_r & imask_r);

  rcic_rtc_edit #(
    .DIGITS (rcic_pkg::RTC_DIGITS)
  ) u_rtc (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .edit      (rtc_edit),
    .key_enter (key_enter),
    .key_up    (key_up),
    .key_down  (key_down),
    .rd_idx    (rtc_idx_r),
    .rd_data_r (rtc_dat),
    .cursor_r  (rtc_cur)
  );

  chk_relay_sysfault: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!lead_r && rsel_r[0] == rcic_pkg::SEL_SYS_FAULT)
      |=> (relay2_make_contact == !$past(system_fault)))
    else $error("relay select 0 does not follow system fault");
  chk_relay_pump: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!lead_r && rsel_r[1] == rcic_pkg::SEL_PUMP && pump_fault) |=> !relay3_make_contact)
    else $error("relay stays closed on pump fault");
  chk_relay_minfreq: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!lead_r && rsel_r[2] == rcic_pkg::SEL_MIN_FREQ)
      |=> (relay4_make_contact == ($past(motor_freq) > $past(minf_r))))
    else $error("relay does not track minimum frequency");
  chk_sel_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    rsel_r[0] <= rcic_pkg::SEL_MAX && rsel_r[1] <= rcic_pkg::SEL_MAX
      && rsel_r[2] <= rcic_pkg::SEL_MAX)
    else $error("relay select out of range");
  chk_leadlag_ovr: assert property (@(posedge core_clk) disable iff (!rst_n)
    lead_r |=> (relay_r == $past(leadlag_relay)))
    else $error("lead/lag does not drive relays");
  chk_break_contact: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!lead_r && rsel_r[0] == rcic_pkg::SEL_SYS_FAULT)
      |=> (relay2_break_contact == $past(system_fault)))
    else $error("relay 2 break contact does not open with no fault");
  chk_analog_rev: assert property (@(posedge core_clk) disable iff (!rst_n)
    arev_r |=> (analog_v_out + $past(analog_v_in) == {AN_W{1'b1}}))
    else $error("analog scale not reversed");
  chk_manual_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mdis_r && mode_req_valid && mode_req == rcic_pkg::REQ_MANUAL)
      |=> mode_r != rcic_pkg::RCIC_MANUAL)
    else $error("manual mode entered while disabled");
  chk_latch_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (latch_r[1] && !clr_fault && !wr_en && cfg_r == rcic_pkg::CFG_DEFAULT
      && fn_r[1] == rcic_pkg::FN_LATCH_OPEN) |=> latch_r[1] ##1 !motor_run)
    else $error("latched fault dropped without enter");
  chk_reverse_in: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_r == rcic_pkg::CFG_DEFAULT && fn_r[2] == rcic_pkg::FN_REVERSE && in_db[2])
      |=> motor_reverse)
    else $error("closed reverse input ignored");
  chk_run_default: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode_r == rcic_pkg::RCIC_AUTO && cfg_r == rcic_pkg::CFG_DEFAULT
      && fn_r[0] == rcic_pkg::FN_RUN_STOP && !in_db[0]) |=> !motor_run)
    else $error("motor runs with input 1 open");
endmodule

// ===== rcic_pkg.sv
// constants shared by the relay and contact input control block
package rcic_pkg;
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          DEBOUNCE_MS   = 10;
  localparam int          DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int          RTC_DIGITS    = 12;
  localparam logic [4:0]  OFS_RELAY_CFG = 5'h00;
  localparam logic [4:0]  OFS_MISC_CFG  = 5'h04;
  localparam logic [4:0]  OFS_INPUT_CFG = 5'h08;
  localparam logic [4:0]  OFS_MIN_FREQ  = 5'h0c;
  localparam logic [4:0]  OFS_STATUS    = 5'h10;
  localparam logic [4:0]  OFS_IRQ_STAT  = 5'h14;
  localparam logic [4:0]  OFS_IRQ_MASK  = 5'h18;
  localparam logic [4:0]  OFS_RTC       = 5'h1c;
  localparam int          FLD_STRIDE    = 4;
  localparam int          MISC_AREV     = 0;
  localparam int          MISC_MDIS     = 1;
  localparam int          MISC_LEAD     = 2;
  localparam int          MISC_CFG_LSB  = 4;
  localparam int          ST_RUN        = 8;
  localparam int          ST_REV        = 9;
  localparam int          ST_RELAY_LSB  = 10;
  localparam int          ST_MODE_LSB   = 13;
  localparam int          RTC_CUR_LSB   = 8;
  localparam int          IRQ_LATCH     = 0;
  localparam int          IRQ_RUN       = 1;
  localparam int          IRQ_RELAY     = 2;
  localparam logic [2:0]  SEL_SYS_FAULT = 3'h0;
  localparam logic [2:0]  SEL_PUMP      = 3'h4;
  localparam logic [2:0]  SEL_MIN_FREQ  = 3'h5;
  localparam logic [2:0]  SEL_MAX       = 3'h5;
  localparam logic [2:0]  FN_RUN_STOP   = 3'h0;
  localparam logic [2:0]  FN_ALWAYS     = 3'h1;
  localparam logic [2:0]  FN_LATCH_OPEN = 3'h2;
  localparam logic [2:0]  FN_REVERSE    = 3'h3;
  localparam logic [2:0]  FN_LATCH_CLS  = 3'h4;
  localparam logic [2:0]  FN_MAX_LOW    = 3'h2;
  localparam logic [2:0]  FN_MAX_HIGH   = 3'h4;
  localparam logic [2:0]  FN_RST_LOW    = 3'h0;
  localparam logic [2:0]  FN_RST_HIGH   = 3'h1;
  localparam logic [2:0]  CFG_DEFAULT   = 3'h0;
  localparam logic [1:0]  REQ_OFF       = 2'h0;
  localparam logic [1:0]  REQ_AUTO      = 2'h1;
  localparam logic [1:0]  REQ_MANUAL    = 2'h2;
  localparam logic [3:0]  DIGIT_MAX     = 4'h9;
  typedef enum logic [1:0] {RCIC_OFF, RCIC_AUTO, RCIC_MANUAL} rcic_mode_t;
endpackage

// ===== rcic_debounce.sv
// two-flop synchroniser and debounce filter for one contact input
`timescale 1ns/10ps
module rcic_debounce #(
  parameter int DEB_CYC = rcic_pkg::DEBOUNCE_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  localparam int CW = $clog2(DEB_CYC + 1);
  logic          s1_r;
  logic          s2_r;
  logic [CW-1:0] cnt_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      dout  <= 1'b0;
    end else if (s2_r == dout) begin
      cnt_r <= '0;
    end else if (cnt_r == CW'(DEB_CYC - 1)) begin
      cnt_r <= '0;
      dout  <= s2_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

// ===== rcic_rtc_edit.sv
// clock digit store with keypad cursor editing
`timescale 1ns/10ps
module rcic_rtc_edit #(
  parameter int DIGITS = rcic_pkg::RTC_DIGITS
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       edit,
  input  wire logic       key_enter,
  input  wire logic       key_up,
  input  wire logic       key_down,
  input  wire logic [3:0] rd_idx,
  output logic      [3:0] rd_data_r,
  output logic      [3:0] cursor_r
);
  logic [3:0] dig_r [DIGITS];
  logic [3:0] cur;

  assign cur = dig_r[cursor_r];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cursor_r <= 4'h0;
    end else if (edit && key_enter) begin
      cursor_r <= (cursor_r == 4'(DIGITS - 1)) ? 4'h0 : cursor_r + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DIGITS; i++) dig_r[i] <= 4'h0;
    end else if (edit && key_up && !key_down) begin
      dig_r[cursor_r] <= (cur >= rcic_pkg::DIGIT_MAX) ? 4'h0 : cur + 4'h1;
    end else if (edit && key_down && !key_up) begin
      dig_r[cursor_r] <= (cur == 4'h0) ? rcic_pkg::DIGIT_MAX : cur - 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= 4'h0;
    end else begin
      rd_data_r <= (rd_idx < 4'(DIGITS)) ? dig_r[rd_idx] : 4'h0;
    end
  end
endmodule

// ===== rcic_field.sv
// dry contact model facing the contact inputs
`timescale 1ns/10ps
module rcic_field (
  input  wire logic       core_clk,
  input  wire logic [3:0] closed,
  output logic      [3:0] contact
);
  // contacts move only on an edge; real bounce is not modelled, the filter sees clean steps
  always_ff @(posedge core_clk) begin
    contact <= closed;
  end
endmodule

// ===== test_relay_and_contact_input_control.sv
// self-checking bench for the relay and contact input control block
`timescale 1ns/10ps
module test_relay_and_contact_input_control;
  typedef struct packed {logic [2:0] sel; logic sf; logic pf; logic [15:0] fq; logic ex;} rcic_row_t;
  logic        core_clk = 1'h0, rst_b = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, irq, system_fault = 1'h0, pump_fault = 1'h0, config_run = 1'h0;
  logic        contact_input_1, contact_input_2, contact_input_3, contact_input_4;
  logic [15:0] motor_freq = 16'h0;
  logic [2:0]  leadlag_relay = 3'h0;
  logic        key_enter = 1'h0, key_up = 1'h0, key_down = 1'h0, rtc_edit = 1'h0;
  logic [1:0]  mode_req = 2'h0, op_mode;
  logic        mode_req_valid = 1'h0;
  logic [9:0]  analog_v_in = 10'h0, analog_i_in = 10'h0, analog_v_out, analog_i_out;
  logic        relay2_make_contact, relay2_break_contact, relay3_make_contact;
  logic        relay4_make_contact, motor_run, motor_reverse, fault_display;
  logic [3:0]  closed = 4'h0, cin;
  int          errors = 0, total_checks = 0, cycles = 0;
  rcic_row_t   rows [10] = '{'{3'h0, 1'h0, 1'h0, 16'h0, 1'h1}, '{3'h0, 1'h1, 1'h0, 16'h0, 1'h0},
    '{3'h6, 1'h0, 1'h0, 16'h0, 1'h1}, '{3'h4, 1'h0, 1'h0, 16'h0, 1'h1},
    '{3'h4, 1'h0, 1'h1, 16'h0, 1'h0}, '{3'h5, 1'h0, 1'h0, 16'h100, 1'h0},
    '{3'h5, 1'h0, 1'h0, 16'h101, 1'h1}, '{3'h1, 1'h0, 1'h0, 16'h0, 1'h0},
    '{3'h2, 1'h0, 1'h0, 16'h0, 1'h0}, '{3'h3, 1'h0, 1'h0, 16'h0, 1'h0}};
  assign {contact_input_4, contact_input_3, contact_input_2, contact_input_1} = cin;
  rcic_field field (.core_clk(core_clk), .closed(closed), .contact(cin));
  rcic_top #(.DEB_CYC(4)) dut (.*);
  always #12.5 core_clk = ~core_clk;
  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // request held until waitrequest is seen low at an edge; a spare edge follows the release
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    tick(1);
  endtask
  task automatic key(input logic [2:0] k);
    {key_enter, key_up, key_down} <= k;
    tick(1);
    {key_enter, key_up, key_down} <= 3'h0;
    tick(1);
  endtask
  task automatic mode(input logic [1:0] m);
    mode_req <= m;
    mode_req_valid <= 1'h1;
    tick(1);
    mode_req_valid <= 1'h0;
    tick(2);
  endtask
  initial begin
    tick(8);
    rst_b <= 1'h1;
    tick(4);
    bus(1'h0, rcic_pkg::OFS_RELAY_CFG, 32'h0);
    chk(q, 32'h0);
    bus(1'h0, rcic_pkg::OFS_INPUT_CFG, 32'h0);
    chk(q, 32'h1100);
    chk({op_mode, relay2_make_contact, relay2_break_contact}, 4'h2);
    $display("reset test done");
    bus(1'h1, rcic_pkg::OFS_MIN_FREQ, 32'h100);
    foreach (rows[i]) begin
      bus(1'h1, rcic_pkg::OFS_RELAY_CFG, {21'h0, rows[i].sel, 1'h0, rows[i].sel, 1'h0, rows[i].sel});
      system_fault <= rows[i].sf;
      pump_fault <= rows[i].pf;
      motor_freq <= rows[i].fq;
      tick(3);
      chk({relay2_make_contact, relay2_break_contact, relay3_make_contact, relay4_make_contact},
          {rows[i].ex, !rows[i].ex, rows[i].ex, rows[i].ex});
    end
    bus(1'h1, rcic_pkg::OFS_MISC_CFG, 32'h4);
    leadlag_relay <= 3'h5;
    tick(3);
    chk({relay2_make_contact, relay3_make_contact, relay4_make_contact}, 3'h5);
    $display("relay test done");
    bus(1'h1, rcic_pkg::OFS_MISC_CFG, 32'h0);
    bus(1'h1, rcic_pkg::OFS_IRQ_MASK, 32'h1);
    mode(rcic_pkg::REQ_AUTO);
    closed <= 4'h3;
    tick(12);
    chk(motor_run, 1'h1);
    closed <= 4'h2;
    tick(12);
    chk(motor_run, 1'h0);
    bus(1'h1, rcic_pkg::OFS_INPUT_CFG, 32'h1101);
    tick(3);
    chk(motor_run, 1'h1);
    bus(1'h1, rcic_pkg::OFS_INPUT_CFG, 32'h1121);
    closed <= 4'h0;
    tick(12);
    chk({motor_run, fault_display, irq}, 3'h3);
    closed <= 4'h2;
    tick(12);
    chk(motor_run, 1'h0);
    key(3'h4);
    tick(2);
    chk({motor_run, fault_display}, 2'h2);
    bus(1'h1, rcic_pkg::OFS_IRQ_STAT, 32'h1);
    chk(irq, 1'h0);
    bus(1'h1, rcic_pkg::OFS_INPUT_CFG, 32'h4321);
    closed <= 4'h6;
    tick(12);
    chk({motor_run, motor_reverse}, 2'h3);
    closed <= 4'he;
    tick(12);
    chk({motor_run, fault_display}, 2'h1);
    closed <= 4'h6;
    tick(12);
    chk({motor_run, fault_display}, 2'h1);
    key(3'h4);
    tick(2);
    chk({motor_run, fault_display}, 2'h2);
    bus(1'h1, rcic_pkg::OFS_MISC_CFG, 32'h10);
    tick(3);
    chk(motor_run, 1'h0);
    config_run <= 1'h1;
    tick(3);
    chk(motor_run, 1'h1);
    $display("contact input test done");
    bus(1'h1, rcic_pkg::OFS_MISC_CFG, 32'h3);
    analog_v_in <= 10'h005;
    analog_i_in <= 10'h3f0;
    tick(3);
    chk({analog_v_out, analog_i_out}, {10'h3fa, 10'h00f});
    mode(rcic_pkg::REQ_OFF);
    mode(rcic_pkg::REQ_MANUAL);
    chk(op_mode, rcic_pkg::REQ_OFF);
    bus(1'h1, rcic_pkg::OFS_MISC_CFG, 32'h0);
    mode(rcic_pkg::REQ_MANUAL);
    chk(op_mode, rcic_pkg::REQ_MANUAL);
    $display("mode test done");
    rtc_edit <= 1'h1;
    key(3'h2);
    key(3'h2);
    key(3'h4);
    key(3'h1);
    bus(1'h1, rcic_pkg::OFS_RTC, 32'h0);
    bus(1'h0, rcic_pkg::OFS_RTC, 32'h0);
    chk(q, 32'h102);
    bus(1'h1, rcic_pkg::OFS_RTC, 32'h1);
    bus(1'h0, rcic_pkg::OFS_RTC, 32'h0);
    chk(q, 32'h109);
    $display("clock edit test done");
    rst_b <= 1'h0;
    tick(2);
    chk({op_mode, motor_run, relay2_make_contact, relay2_break_contact, irq}, 6'h2);
    rst_b <= 1'h1;
    tick(4);
    chk(relay2_make_contact, 1'h1);
    bus(1'h0, rcic_pkg::OFS_INPUT_CFG, 32'h0);
    chk(q, 32'h1100);
    bus(1'h0, rcic_pkg::OFS_RTC, 32'h0);
    chk(q, 32'h0);
    $display("second reset test done");
    print_verdict();
  end
endmodule
